// ### verilog/acrm_pkg.sv
// Shared constants and types of the converter register bank
package acrm_pkg;
   localparam int         REG_COUNT        = 16;
   localparam int         DATA_W           = 32;
   localparam int         FIELD_W          = 24;
   localparam logic [3:0] ADDR_RESULT      = 4'h0;
   localparam logic [3:0] ADDR_CFG0        = 4'h1;
   localparam logic [3:0] ADDR_CFG1        = 4'h2;
   localparam logic [3:0] ADDR_CFG2        = 4'h3;
   localparam logic [3:0] ADDR_CFG3        = 4'h4;
   localparam logic [3:0] ADDR_EVENT       = 4'h5;
   localparam logic [3:0] ADDR_INPUT_SEL   = 4'h6;
   localparam logic [3:0] ADDR_SEQ_SETUP   = 4'h7;
   localparam logic [3:0] ADDR_SEQ_DELAY   = 4'h8;
   localparam logic [3:0] ADDR_OFFSET_CORR = 4'h9;
   localparam logic [3:0] ADDR_GAIN_CORR   = 4'ha;
   localparam logic [3:0] ADDR_SPARE_B     = 4'hb;
   localparam logic [3:0] ADDR_SPARE_C     = 4'hc;
   localparam logic [3:0] ADDR_WR_KEY      = 4'hd;
   localparam logic [3:0] ADDR_SPARE_E     = 4'he;
   localparam logic [3:0] ADDR_CHECKSUM    = 4'hf;
   // Widths in bits of each slot; slot 0 is sized by the output format
   localparam logic [5:0] RF_WIDTH [REG_COUNT] = '{
      6'h20, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h08, 6'h18,
      6'h18, 6'h18, 6'h18, 6'h18, 6'h08, 6'h08, 6'h10, 6'h10};
   localparam logic [23:0] RF_RESET [REG_COUNT] = '{
      24'h000000, 24'h0000c0, 24'h00000c, 24'h00008b, 24'h000000, 24'h000000,
      24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
      24'h000000, 24'h000000, 24'h000000, 24'h000000};
   localparam logic [5:0] WIDTH_RAW        = 6'h04;
   localparam logic [5:0] WIDTH_16         = 6'h10;
   localparam logic [5:0] WIDTH_32         = 6'h20;
   // Field positions
   localparam int         OPMODE_LSB       = 0;
   localparam int         BIAS_LSB         = 2;
   localparam int         CLKSEL_LSB       = 4;
   localparam int         FORCE_LSB        = 6;
   localparam int         GAIN_EN_BIT      = 0;
   localparam int         OFFSET_EN_BIT    = 1;
   localparam int         FMT_LSB          = 4;
   localparam int         CONVERSION_MODE_SEL_LSB    = 6;
   localparam int         RAW_MODE_BIT     = 3;
   localparam int         CORR_LSB         = 8;
   localparam int         GAIN_FRAC        = 15;
   // Field codes
   localparam logic [1:0] OPMODE_CONV      = 2'h3;
   localparam logic [1:0] OPMODE_STANDBY   = 2'h2;
   localparam logic [1:0] OPMODE_SHUTDOWN  = 2'h0;
   localparam logic [1:0] CLKSEL_INT       = 2'h2;
   localparam logic [1:0] CLKSEL_INT_OUT   = 2'h3;
   localparam logic [1:0] FMT_16           = 2'h0;
   localparam logic [1:0] FMT_32_LEFT      = 2'h1;
   localparam logic [1:0] FMT_32_SIGN      = 2'h2;
   localparam logic [1:0] FMT_32_CHANNEL_IDENTIFIER      = 2'h3;
   localparam logic [1:0] CONV_CONTINUOUS  = 2'h3;
   localparam logic [1:0] CONV_TO_STANDBY  = 2'h2;
   // Serial command byte: address in bits 5-2, access type in bits 1-0
   localparam logic [5:0] CMD_LAST_BIT     = 6'h07;
   localparam int         CMD_ADDR_LSB     = 2;
   localparam logic [1:0] CMD_WRITE        = 2'h2;
   localparam logic [1:0] CMD_READ         = 2'h3;
   localparam logic [15:0] CRC_POLY        = 16'h8005;
   localparam logic [15:0] CRC_INIT        = 16'hffff;
   localparam logic [7:0] WR_KEY_DEFAULT   = 8'ha5;

   typedef struct packed {
      logic [15:0] code;
      logic [3:0]  channel_identifier;
      logic [3:0]  raw_modulator_output;
   } acrm_sample_type;

   typedef enum logic [1:0] {
      ACRM_IDLE = 2'b00,
      ACRM_CMD  = 2'b01,
      ACRM_DATA = 2'b11,
      ACRM_HALT = 2'b10
   } acrm_state_type;
endpackage

// ### verilog/acrm_register_bank.sv
// Register bank and mode control of a delta-sigma converter behind its serial port
// How it works
// - Sixteen volatile registers, reached one after another with address auto-increment.
// - Slot 0 is read-only result, 16 or 32 bits by format, 4 in raw mode.
// - Slot 1 is 8-bit read/write: operating mode, clock source, bias current.
// - Slots 2 to 4 are 8-bit read/write configuration bytes.
// - Slot 5 is 8-bit read/write event status and control.
// - Slot 6 is 8-bit read/write input selection.
// - Slots 7 and 8 are 24-bit read/write sequencer setup and cycle delay.
// - Slots 9 and 10 are 24-bit offset and gain correction values.
// - Slot 13 is an 8-bit key; a wrong key locks serial writes to every slot except the key slot itself.
// - Slot 15 is read-only 16-bit checksum over the configuration.
// - Result gets offset and gain correction when their enables are set.
// - Result holds the newest conversion, refreshed on each data-ready seen while the clock enable is high.
// - Result is captured as the last bit of each read command byte arrives.
// - Captured copy is a second buffer so a new conversion never tears a word being read.
// - Raw mode shrinks the result to the four modulator comparator bits.
// - Bits 7-6 of slot 1 are inert unless the whole byte is zero: full shutdown.
// - Clock code 10 selects internal oscillator, no clock out; 0x external.
// - Bias code 10 is 3.7 uA, 01 is 0.9 uA, 00 none.
// - Mode 11 converts, 10 standby, 01 and 00 shut down.
// - Conversion mode 11 runs on; 10 ends in standby, 0x in shutdown.
// - Format 00 16-bit, 01 left-justified clamped, 10 sign-extended, 11 with channel id.
`timescale 1ns/1ps
module acrm_register_bank #(
   parameter logic [7:0] WR_KEY = acrm_pkg::WR_KEY_DEFAULT
) (
   input  wire logic                      core_clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      clk_en_i,
   input  wire logic                      spi_cs_n_i,
   input  wire logic                      spi_sck_i,
   input  wire logic                      spi_mosi_i,
   input  wire logic                      data_ready_i,
   input  wire acrm_pkg::acrm_sample_type sample_i,
   input  wire logic                      conv_done_i,
   output logic                           spi_miso_o,
   output logic                           spi_miso_oe_o,
   output logic [1:0]                     op_mode_o,
   output logic                           full_shutdown_o,
   output logic                           internal_osc_o,
   output logic                           clk_out_en_o,
   output logic [1:0]                     bias_sel_o,
   output logic                           raw_mode_o,
   output logic                           write_locked_o
);
   logic [23:0]              rf_reg [acrm_pkg::REG_COUNT];
   logic [31:0]              result_reg;
   logic [31:0]              result_cap_reg;
   logic [15:0]              checksum_reg;
   logic [2:0]               sck_sync_reg;
   logic [1:0]               cs_sync_reg;
   logic [1:0]               mosi_sync_reg;
   acrm_pkg::acrm_state_type state_reg;
   logic [5:0]               bit_cnt_reg;
   logic [3:0]               addr_reg;
   logic                     is_write_reg;
   logic                     load_pending_reg;
   logic [31:0]              rx_reg;
   logic [31:0]              tx_reg;
   logic                     miso_reg;
   logic                     miso_oe_reg;

   logic                     sck_rise;
   logic                     sck_fall;
   logic                     cs_n_s;
   logic                     mosi_s;
   logic [7:0]               cmd_byte;
   logic [1:0]               fmt;
   logic                     raw_mode;
   logic [5:0]               cur_width;
   logic [31:0]              cur_value;
   logic [31:0]              load_word;
   logic [31:0]              wr_data;
   logic                     wr_fire;
   logic                     wr_ok;
   logic [23:0]              wr_mask;
   logic signed [18:0]       corr;
   logic signed [35:0]       prod;
   logic [15:0]              sat16;
   logic [16:0]              sat17;
   logic [31:0]              result_word;
   logic [15:0]              crc_calc;
   logic                     crc_fb;

   assign spi_miso_o    = miso_reg;
   assign spi_miso_oe_o = miso_oe_reg;

   assign cs_n_s   = cs_sync_reg[1];
   assign mosi_s   = mosi_sync_reg[1];
   assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
   assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
   assign cmd_byte = {rx_reg[6:0], mosi_s};
   assign wr_data  = {rx_reg[30:0], mosi_s};
   assign fmt      = rf_reg[acrm_pkg::ADDR_CFG3][acrm_pkg::FMT_LSB +: 2];
   assign raw_mode = rf_reg[acrm_pkg::ADDR_EVENT][acrm_pkg::RAW_MODE_BIT];

   // Pin synchronisers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sck_sync_reg  <= 3'h0;
         cs_sync_reg   <= 2'h3;
         mosi_sync_reg <= 2'h0;
      end else if (clk_en_i) begin
         sck_sync_reg  <= {sck_sync_reg[1:0], spi_sck_i};
         cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n_i};
         mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_i};
      end
   end

   // Width and value of the slot under the pointer
   always_comb begin
      cur_width = acrm_pkg::RF_WIDTH[addr_reg];
      cur_value = {8'h00, rf_reg[addr_reg]};
      if (addr_reg == acrm_pkg::ADDR_RESULT) begin
         if (raw_mode) begin
            cur_width = acrm_pkg::WIDTH_RAW;
         end else if (fmt == acrm_pkg::FMT_16) begin
            cur_width = acrm_pkg::WIDTH_16;
         end else begin
            cur_width = acrm_pkg::WIDTH_32;
         end
         cur_value = result_cap_reg;
      end else if (addr_reg == acrm_pkg::ADDR_CHECKSUM) begin
         cur_value = {16'h0000, checksum_reg};
      end
      load_word = cur_value << (acrm_pkg::WIDTH_32 - cur_width);
   end

   // Write decode: key slot always writable, others only with the key in place
   always_comb begin
      wr_fire = (state_reg == acrm_pkg::ACRM_DATA) && is_write_reg && sck_rise
                && (bit_cnt_reg == cur_width - 6'h01);
      wr_ok   = (addr_reg == acrm_pkg::ADDR_WR_KEY)
                || (rf_reg[acrm_pkg::ADDR_WR_KEY][7:0] == WR_KEY);
      wr_mask = 24'(~(32'hffffffff << cur_width));
   end

   // Serial command and data engine, mode 0,0
   // Command bits 5-2 carry the slot, bits 1-0 the access type
   // A slot cut short by chip-select rising is dropped, never half written
   // Read data launches on the synced clock fall, so it is settled before the next rise
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg        <= acrm_pkg::ACRM_IDLE;
         bit_cnt_reg      <= 6'h00;
         addr_reg         <= 4'h0;
         is_write_reg     <= 1'b0;
         load_pending_reg <= 1'b0;
         rx_reg           <= 32'h00000000;
         tx_reg           <= 32'h00000000;
         miso_reg         <= 1'b0;
         miso_oe_reg      <= 1'b0;
         result_cap_reg   <= 32'h00000000;
      end else if (clk_en_i) begin
         miso_oe_reg <= ~cs_n_s && (state_reg == acrm_pkg::ACRM_DATA) && ~is_write_reg;
         if (cs_n_s) begin
            state_reg        <= acrm_pkg::ACRM_IDLE;
            bit_cnt_reg      <= 6'h00;
            load_pending_reg <= 1'b0;
            miso_reg         <= 1'b0;
         end else begin
            unique case (state_reg)
               acrm_pkg::ACRM_IDLE: begin
                  state_reg   <= acrm_pkg::ACRM_CMD;
                  bit_cnt_reg <= 6'h00;
               end
               acrm_pkg::ACRM_CMD: begin
                  if (sck_rise) begin
                     rx_reg      <= wr_data;
                     bit_cnt_reg <= bit_cnt_reg + 6'h01;
                     if (bit_cnt_reg == acrm_pkg::CMD_LAST_BIT) begin
                        bit_cnt_reg <= 6'h00;
                        addr_reg    <= cmd_byte[acrm_pkg::CMD_ADDR_LSB +: 4];
                        if (cmd_byte[1:0] == acrm_pkg::CMD_READ) begin
                           state_reg        <= acrm_pkg::ACRM_DATA;
                           is_write_reg     <= 1'b0;
                           load_pending_reg <= 1'b1;
                           result_cap_reg   <= result_reg;
                        end else if (cmd_byte[1:0] == acrm_pkg::CMD_WRITE) begin
                           state_reg    <= acrm_pkg::ACRM_DATA;
                           is_write_reg <= 1'b1;
                        end else begin
                           state_reg <= acrm_pkg::ACRM_HALT;
                        end
                     end
                  end
               end
               acrm_pkg::ACRM_DATA: begin
                  if (sck_rise) begin
                     rx_reg <= wr_data;
                     if (bit_cnt_reg == cur_width - 6'h01) begin
                        bit_cnt_reg      <= 6'h00;
                        addr_reg         <= addr_reg + 4'h1;
                        load_pending_reg <= ~is_write_reg;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg + 6'h01;
                     end
                  end
                  if (sck_fall && ~is_write_reg) begin
                     if (load_pending_reg) begin
                        tx_reg           <= load_word << 1;
                        miso_reg         <= load_word[31];
                        load_pending_reg <= 1'b0;
                     end else begin
                        tx_reg   <= tx_reg << 1;
                        miso_reg <= tx_reg[31];
                     end
                  end
               end
               acrm_pkg::ACRM_HALT: begin
                  miso_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // Register file; end-of-conversion mode update overrides a host write
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < acrm_pkg::REG_COUNT; i++) begin
            rf_reg[i] <= acrm_pkg::RF_RESET[i];
         end
      end else if (clk_en_i) begin
         if (wr_fire && wr_ok && (addr_reg != acrm_pkg::ADDR_RESULT)
             && (addr_reg != acrm_pkg::ADDR_CHECKSUM)) begin
            rf_reg[addr_reg] <= wr_data[23:0] & wr_mask;
         end
         if (conv_done_i
             && (rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::OPMODE_LSB +: 2] == acrm_pkg::OPMODE_CONV)
             && (rf_reg[acrm_pkg::ADDR_CFG3][acrm_pkg::CONVERSION_MODE_SEL_LSB +: 2]
                 != acrm_pkg::CONV_CONTINUOUS)) begin
            if (rf_reg[acrm_pkg::ADDR_CFG3][acrm_pkg::CONVERSION_MODE_SEL_LSB +: 2]
                == acrm_pkg::CONV_TO_STANDBY) begin
               rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::OPMODE_LSB +: 2] <=
                  acrm_pkg::OPMODE_STANDBY;
            end else begin
               rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::OPMODE_LSB +: 2] <=
                  acrm_pkg::OPMODE_SHUTDOWN;
            end
         end
      end
   end

   // Corrected and formatted conversion word
   // Offset is added before the gain product; both saturate at the end
   always_comb begin
      corr = 19'(signed'(sample_i.code));
      prod = 36'sh0;
      if (rf_reg[acrm_pkg::ADDR_CFG3][acrm_pkg::OFFSET_EN_BIT]) begin
         corr = corr + 19'(signed'(rf_reg[acrm_pkg::ADDR_OFFSET_CORR][acrm_pkg::CORR_LSB +: 16]));
      end
      if (rf_reg[acrm_pkg::ADDR_CFG3][acrm_pkg::GAIN_EN_BIT]) begin
         prod = 36'(corr) * 36'(signed'({1'b0,
                rf_reg[acrm_pkg::ADDR_GAIN_CORR][acrm_pkg::CORR_LSB +: 16]}));
         corr = 19'(prod >>> acrm_pkg::GAIN_FRAC);
      end
      if (corr > 19'sh07fff) begin
         sat16 = 16'h7fff;
      end else if (corr < -19'sh08000) begin
         sat16 = 16'h8000;
      end else begin
         sat16 = corr[15:0];
      end
      if (corr > 19'sh0ffff) begin
         sat17 = 17'h0ffff;
      end else if (corr < -19'sh10000) begin
         sat17 = 17'h10000;
      end else begin
         sat17 = corr[16:0];
      end
      unique case (fmt)
         acrm_pkg::FMT_16:      result_word = {16'h0000, sat16};
         acrm_pkg::FMT_32_LEFT: result_word = {sat16, 16'h0000};
         acrm_pkg::FMT_32_SIGN: result_word = {{15{sat17[16]}}, sat17};
         acrm_pkg::FMT_32_CHANNEL_IDENTIFIER: result_word = {sample_i.channel_identifier,
                                               {11{sat17[16]}}, sat17};
      endcase
      if (raw_mode) begin
         result_word = {28'h0000000, sample_i.raw_modulator_output};
      end
   end

   // Latest result; a read in progress shifts the captured copy instead,
   // so a refresh here never tears a word on the wire
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         result_reg <= 32'h00000000;
      end else if (clk_en_i && data_ready_i) begin
         result_reg <= result_word;
      end
   end

   // Configuration checksum over slots 1 to 13
   // Recomputed every cycle; the registered copy settles one cycle after a write
   always_comb begin
      crc_calc = acrm_pkg::CRC_INIT;
      crc_fb   = 1'b0;
      for (int a = 1; a <= 13; a++) begin
         for (int b = acrm_pkg::FIELD_W - 1; b >= 0; b--) begin
            crc_fb   = crc_calc[15] ^ rf_reg[a][b];
            crc_calc = {crc_calc[14:0], 1'b0} ^ (crc_fb ? acrm_pkg::CRC_POLY : 16'h0000);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         checksum_reg <= 16'h0000;
      end else if (clk_en_i) begin
         checksum_reg <= crc_calc;
      end
   end

   // Decoded mode outputs
   // Each lags the register file by one cycle so every output leaves a flip-flop
   // Writes stay locked out of reset until the host loads the key
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         op_mode_o       <= acrm_pkg::OPMODE_SHUTDOWN;
         full_shutdown_o <= 1'b0;
         internal_osc_o  <= 1'b0;
         clk_out_en_o    <= 1'b0;
         bias_sel_o      <= 2'h0;
         raw_mode_o      <= 1'b0;
         write_locked_o  <= 1'b1;
      end else if (clk_en_i) begin
         op_mode_o       <= rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::OPMODE_LSB +: 2];
         full_shutdown_o <= (rf_reg[acrm_pkg::ADDR_CFG0][7:0] == 8'h00);
         internal_osc_o  <= rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::CLKSEL_LSB + 1];
         clk_out_en_o    <= (rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::CLKSEL_LSB +: 2]
                             == acrm_pkg::CLKSEL_INT_OUT);
         bias_sel_o      <= rf_reg[acrm_pkg::ADDR_CFG0][acrm_pkg::BIAS_LSB +: 2];
         raw_mode_o      <= raw_mode;
         write_locked_o  <= (rf_reg[acrm_pkg::ADDR_WR_KEY][7:0] != WR_KEY);
      end
   end
endmodule

// ### dv/acrm_register_bank_sva.sv
// Port checks of the converter register bank
`timescale 1ns/1ps
module acrm_register_bank_sva (
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       spi_cs_n_i,
   input wire logic       spi_sck_i,
   input wire logic       conv_done_i,
   input wire logic       spi_miso_o,
   input wire logic       spi_miso_oe_o,
   input wire logic [1:0] op_mode_o,
   input wire logic       full_shutdown_o,
   input wire logic       internal_osc_o,
   input wire logic       clk_out_en_o,
   input wire logic [1:0] bias_sel_o,
   input wire logic       raw_mode_o,
   input wire logic       write_locked_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   chk_oe_idle: assert property (spi_cs_n_i [*8] |-> !spi_miso_oe_o)
      else $error("miso enabled while deselected");
   chk_oe_frame: assert property ($rose(spi_miso_oe_o) |-> !spi_cs_n_i)
      else $error("miso enable rose outside a frame");
   chk_shutdown_all: assert property (full_shutdown_o |->
      op_mode_o == 2'h0 && bias_sel_o == 2'h0 && !internal_osc_o && !clk_out_en_o)
      else $error("full shutdown with live fields");
   chk_clk_out: assert property (clk_out_en_o |-> internal_osc_o)
      else $error("clock out without internal oscillator");
   chk_conv_end: assert property (conv_done_i && op_mode_o == 2'h3 |-> ##2 op_mode_o != 2'h1)
      else $error("bad mode after end of conversion");
   chk_mode_cause: assert property ($changed(op_mode_o) |->
      $past(conv_done_i, 2) || !$past(spi_cs_n_i, 2))
      else $error("mode changed without cause");
   chk_lock_cause: assert property ($changed(write_locked_o) |-> !$past(spi_cs_n_i, 2))
      else $error("lock changed outside a frame");
   chk_lock_reset: assert property ($fell(rst_i) |-> write_locked_o)
      else $error("writes open after reset");
   chk_miso_steady: assert property (spi_sck_i [*6] |-> $stable(spi_miso_o))
      else $error("miso moved while clock high");
   chk_raw_cause: assert property ($changed(raw_mode_o) |-> !$past(spi_cs_n_i, 2))
      else $error("raw mode changed outside a frame");
   cov_unlock: cover property ($fell(write_locked_o));
   cov_conv_end: cover property (conv_done_i && op_mode_o == 2'h3);
   cov_raw: cover property ($rose(raw_mode_o));
   cov_shutdown: cover property ($rose(full_shutdown_o));
endmodule
bind acrm_register_bank acrm_register_bank_sva u_sva (.core_clk_i, .rst_i, .spi_cs_n_i,
   .spi_sck_i, .conv_done_i, .spi_miso_o, .spi_miso_oe_o, .op_mode_o, .full_shutdown_o,
   .internal_osc_o, .clk_out_en_o, .bias_sel_o, .raw_mode_o, .write_locked_o);

// ### dv/acrm_host_model.sv
// Serial host model: one framed transfer per call, MSB first, clock idle low
`timescale 1ns/1ps
module acrm_host_model (
   input  wire logic  core_clk_i,
   input  wire logic  miso_i,
   output logic       cs_n_o,
   output logic       sck_o,
   output logic       mosi_o,
   output logic       rd_valid_o,
   output logic [63:0] rd_data_o
);
   localparam int HALF = 6;
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      mosi_o = 1'b0;
      rd_valid_o = 1'b0;
      rd_data_o = '0;
   end
   // Released data line toggles so a stale level never passes for data
   always @(posedge core_clk_i) if (cs_n_o) mosi_o <= ~mosi_o;
   task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [63:0] wdata);
      logic [63:0] rd;
      int          k;
      rd = '0;
      @(negedge core_clk_i);
      cs_n_o = 1'b0;
      for (int i = 7 + nbits; i >= 0; i--) begin
         k = (i >= nbits) ? i - nbits : 0;
         @(negedge core_clk_i);
         mosi_o = (i >= nbits) ? cmd[k] : wdata[i];
         // Settle time before the first edge also covers the wait after data ready
         repeat (HALF - 1) @(negedge core_clk_i);
         if (i < nbits) rd[i] = miso_i;
         sck_o = 1'b1;
         repeat (HALF) @(negedge core_clk_i);
         sck_o = 1'b0;
      end
      repeat (HALF) @(negedge core_clk_i);
      cs_n_o = 1'b1;
      if (cmd[1:0] == 2'h3) begin
         rd_data_o = rd;
         rd_valid_o = 1'b1;
         @(negedge core_clk_i);
         rd_valid_o = 1'b0;
      end
      repeat (HALF) @(negedge core_clk_i);
   endtask
endmodule

// ### dv/test_adc_register_map_and_mode_control.sv
// Self-checking bench of the converter register bank
`timescale 1ns/1ps
module test_adc_register_map_and_mode_control;
   logic                      core_clk_i = 1'b0;
   logic                      rst_i = 1'b1;
   logic                      clk_en_i = 1'b1;
   logic                      data_ready_i = 1'b0;
   logic                      conv_done_i = 1'b0;
   logic                      tgl = 1'b0;
   acrm_pkg::acrm_sample_type sample_i = '0;
   acrm_pkg::acrm_sample_type smp;
   logic                      cs_n, sck, mosi, miso, miso_q, miso_oe;
   logic                      fsd, osc, clko, raw, lock, rd_valid;
   logic [1:0]                op_mode, bias;
   logic [63:0]               rd_data, wv;
   logic [63:0]               exp_q [$];
   logic [7:0]                cfg [6] = '{8'h00, 8'hc0, 8'h40, 8'h39, 8'h26, 8'h17};
   logic [7:0]                cm [3] = '{8'hc0, 8'h80, 8'h00};
   logic [1:0]                em [3] = '{2'h3, 2'h2, 2'h0};
   int                        num_errors = 0;
   int                        n_tests = 0;
   assign miso = miso_oe ? miso_q : tgl;
   always @(posedge core_clk_i) tgl <= ~tgl;
   initial forever #20 core_clk_i = ~core_clk_i;
   acrm_register_bank uut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .spi_cs_n_i(cs_n),
      .spi_sck_i(sck), .spi_mosi_i(mosi), .data_ready_i(data_ready_i), .sample_i(sample_i),
      .conv_done_i(conv_done_i), .spi_miso_o(miso_q), .spi_miso_oe_o(miso_oe),
      .op_mode_o(op_mode), .full_shutdown_o(fsd), .internal_osc_o(osc),
      .clk_out_en_o(clko), .bias_sel_o(bias), .raw_mode_o(raw), .write_locked_o(lock));
   acrm_host_model host (.core_clk_i(core_clk_i), .miso_i(miso), .cs_n_o(cs_n), .sck_o(sck),
      .mosi_o(mosi), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   function automatic int wd(input int a);
      return (a == 0) ? 16 : int'(acrm_pkg::RF_WIDTH[a]);
   endfunction
   function automatic logic [63:0] mask(input int n);
      return (64'h1 << n) - 64'h1;
   endfunction
   // Checksum expected over slots 1 to 13 holding their reset values
   function automatic logic [63:0] crc_reset();
      logic [15:0] c;
      c = acrm_pkg::CRC_INIT;
      for (int a = 1; a <= 13; a++) begin
         for (int b = 23; b >= 0; b--) begin
            c = {c[14:0], 1'b0}
                ^ ((c[15] ^ acrm_pkg::RF_RESET[a][b]) ? acrm_pkg::CRC_POLY : 16'h0000);
         end
      end
      return 64'(c);
   endfunction
   task automatic wr(input int a, input int n, input logic [63:0] d);
      host.xfer({2'b00, 4'(a), acrm_pkg::CMD_WRITE}, n, d);
   endtask
   task automatic rd(input int a, input int n, input logic [63:0] e);
      exp_q.push_back(e);
      host.xfer({2'b00, 4'(a), acrm_pkg::CMD_READ}, n, 64'h0);
   endtask
   task automatic ready(input acrm_pkg::acrm_sample_type s);
      @(negedge core_clk_i);
      sample_i = s;
      data_ready_i = 1'b1;
      @(negedge core_clk_i);
      data_ready_i = 1'b0;
   endtask
   // Read results are compared in order as the host hands them back
   always @(posedge core_clk_i) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) num_errors++;
         else check(rd_data, exp_q.pop_front());
      end
   end
   initial begin
      repeat (100000) @(posedge core_clk_i);
      num_errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(23));
      repeat (16) @(negedge core_clk_i);
      rst_i = 1'b0;
      wr(2, 8, 64'h55);
      for (int a = 0; a <= 15; a++) begin
         rd(a, wd(a), (a == 15) ? crc_reset() : acrm_pkg::RF_RESET[a] & mask(wd(a)));
      end
      check(lock, 1'b1);
      wr(13, 8, 64'(acrm_pkg::WR_KEY_DEFAULT));
      check(lock, 1'b0);
      for (int a = 2; a <= 12; a++) if (a != 5) begin
         wv = {$urandom, $urandom} & mask(wd(a));
         wr(a, wd(a), wv);
         rd(a, wd(a), wv);
      end
      wr(11, 32, 64'h1234569c);
      rd(11, 32, 64'h1234569c);
      wr(2, 8, 64'h5a);
      wr(13, 8, 64'h00);
      wr(2, 8, 64'h33);
      wr(13, 8, 64'(acrm_pkg::WR_KEY_DEFAULT));
      rd(2, 8, 64'h5a);
      foreach (cfg[i]) begin
         wr(1, 8, 64'(cfg[i]));
         rd(1, 8, 64'(cfg[i]));
         check({op_mode, bias, osc, clko, fsd}, {cfg[i][1:0], cfg[i][3:2], cfg[i][5],
            &cfg[i][5:4], cfg[i] == 8'h00});
      end
      foreach (cm[i]) begin
         wr(4, 8, 64'(cm[i]));
         wr(1, 8, 64'h03);
         @(negedge core_clk_i);
         conv_done_i = 1'b1;
         @(negedge core_clk_i);
         conv_done_i = 1'b0;
         repeat (3) @(negedge core_clk_i);
         check(op_mode, em[i]);
      end
      for (int f = 0; f < 4; f++) begin
         smp = acrm_pkg::acrm_sample_type'(24'($urandom));
         wr(4, 8, 64'(f << 4));
         ready(smp);
         case (f)
            0: rd(0, 16, 64'(smp.code));
            1: rd(0, 32, {smp.code, 16'h0000});
            2: rd(0, 32, {{16{smp.code[15]}}, smp.code});
            default: rd(0, 32, {smp.channel_identifier, {12{smp.code[15]}}, smp.code});
         endcase
      end
      wr(5, 8, 64'h08);
      ready(smp);
      check(raw, 1'b1);
      rd(0, 4, 64'(smp.raw_modulator_output));
      wr(5, 8, 64'h00);
      wr(9, 24, 64'h001000);
      wr(4, 8, 64'h02);
      ready('{16'h1234, 4'h0, 4'h0});
      rd(0, 16, 64'h1244);
      wr(4, 8, 64'h00);
      ready('{16'h0a5a, 4'h0, 4'h0});
      fork
         rd(0, 16, 64'h0a5a);
         begin
            repeat (150) @(negedge core_clk_i);
            ready('{16'h3cc3, 4'h0, 4'h0});
         end
      join
      wr(0, 16, 64'hffff);
      rd(0, 16, 64'h3cc3);
      clk_en_i = 1'b0;
      ready('{16'h7001, 4'h0, 4'h0});
      clk_en_i = 1'b1;
      rd(0, 16, 64'h3cc3);
      repeat (4) @(negedge core_clk_i);
      if (exp_q.size() != 0) num_errors++;
      tally_and_finish;
   end
endmodule
